// ---- verilog/dsw_pkg.sv ----
/*
 * Package for the double-data-rate SRAM write port model and its controller.
 * Holds widths, encodings and constants shared by both ends.
 * Assumes a single system clock; the link half-clock phases are enables.
 */
package dsw_pkg;
	localparam int DATA_W   = 8;
	localparam int NIB_W    = 4;
	localparam int ADDR_W   = 6;
	localparam int DEPTH    = 128;
	localparam int WORD_IDX = 7;
	// Direction encoding on the direction pin
	localparam logic DIR_READ  = 1'b1;
	localparam logic DIR_WRITE = 1'b0;
	// Idle and active levels of active-low strobes
	localparam logic STROBE_IDLE = 1'b1;
	localparam logic STROBE_ACT  = 1'b0;
	// Nibble positions inside a word
	localparam int LO_NIB_LSB = 0;
	localparam int HI_NIB_LSB = 4;
	// Burst length in words
	localparam int BURST_LEN = 2;

	typedef enum logic [1:0] {
		DSW_IDLE  = 2'b00,
		DSW_FIRST = 2'b01,
		DSW_SECND = 2'b10
	} dsw_state_t;
endpackage

// ---- verilog/dsw_link_if.sv ----
/*
 * Link between the memory controller and the SRAM write port.
 * Assumes both ends run on clk_sys; k_rise and kn_rise mark the two
 * input clock edges as one-cycle enables.
 */
`timescale 1ns/1ps
interface dsw_link_if;
	import dsw_pkg::*;
	logic                k_rise;
	logic                kn_rise;
	logic                load_strobe_n;
	logic                rw_dir;
	logic [ADDR_W-1:0]   addr;
	logic [DATA_W-1:0]   data_in;
	logic                low_nibble_write_sel_n;
	logic                high_nibble_write_sel_n;

	modport ctrl (
		output k_rise, kn_rise, load_strobe_n, rw_dir, addr, data_in,
		output low_nibble_write_sel_n, high_nibble_write_sel_n
	);
	modport sram (
		input k_rise, kn_rise, load_strobe_n, rw_dir, addr, data_in,
		input low_nibble_write_sel_n, high_nibble_write_sel_n
	);
endinterface

// ---- verilog/dsw_sram_port.sv ----
/*
 * SRAM write-port end of the double-data-rate link.
 * Holds the transaction sequencer, which takes a burst definition on a
 * positive clock edge, a count of the words of the running burst, and a
 * small flip-flop array that receives two words per write burst, each
 * with its own pair of nibble selects.
 * Also holds a registered read-back port for the array, a one-cycle
 * pulse for every read definition taken outside DSW_FIRST and a busy level for write bursts.
 * Assumes the controller drives the link synchronously to clk_sys, so
 * no link signal needs a synchroniser.
 * Assumes k_rise and kn_rise are one-cycle enables that alternate with
 * at least one idle cycle between them.
 * Assumes reset_n is synchronous; the array itself is not reset.
 */
`timescale 1ns/1ps
module dsw_sram_port
	import dsw_pkg::*;
(
	// Clock and reset
	input  wire logic                clk_sys,
	input  wire logic                reset_n,
	// Link
	dsw_link_if.sram                 link,
	// User side: read-back of the array and status
	input  wire logic [WORD_IDX-1:0] rd_idx,
	output logic      [DATA_W-1:0]   rd_data,
	output logic                     wr_busy,
	output logic                     rd_req
);
	// Counter width holds the full burst length
	localparam int CNT_W = $clog2(BURST_LEN + 1);

	// Sequencer state
	dsw_state_t               state_ff, nxt_state;
	logic      [ADDR_W-1:0]   addr_ff, nxt_addr;
	logic                     dir_ff, nxt_dir;
	logic                     rd_req_ff, nxt_rd_req;
	logic      [CNT_W-1:0]    word_cnt_ff, nxt_word_cnt;
	// Array and read-back
	logic      [DATA_W-1:0]   mem_ff [DEPTH];
	logic      [DATA_W-1:0]   rd_data_ff, nxt_rd_data;
	// Decoded link events
	logic                     load_take;
	logic                     load_write;
	logic                     word0_take;
	logic                     word1_take;
	// Selects of the current edge, active high inside the block
	logic                     lo_sel;
	logic                     hi_sel;
	// Write path
	logic                     wr_en;
	logic      [WORD_IDX-1:0] wr_idx;
	logic      [DATA_W-1:0]   wr_mask;
	logic      [DATA_W-1:0]   wr_word;

	// A definition is taken only on a positive edge with the load low
	assign load_take  = link.k_rise && (link.load_strobe_n == STROBE_ACT);
	assign load_write = load_take && (link.rw_dir == DIR_WRITE);

	// Burst words: the first on the positive edge a period after the load,
	// the second on the negative edge that follows; the count closes the burst
	assign word0_take = link.k_rise && (state_ff == DSW_FIRST)
		&& (dir_ff == DIR_WRITE);
	assign word1_take = link.kn_rise && (state_ff == DSW_SECND)
		&& (word_cnt_ff == CNT_W'(BURST_LEN - 1));

	// Selects are sampled with the data word of the same edge
	assign lo_sel = (link.low_nibble_write_sel_n == STROBE_ACT);
	assign hi_sel = (link.high_nibble_write_sel_n == STROBE_ACT);

	// Transaction sequencing: next state, captured definition, read pulse
	always_comb begin
		nxt_state  = state_ff;
		nxt_addr   = addr_ff;
		nxt_dir    = dir_ff;
		nxt_rd_req = 1'b0;
		unique case (state_ff)
			DSW_IDLE: begin
				if (load_take) begin
					nxt_addr = link.addr;
					nxt_dir  = link.rw_dir;
					if (load_write) begin
						nxt_state = DSW_FIRST;
					end else begin
						nxt_rd_req = 1'b1;
					end
				end
			end
			DSW_FIRST: begin
				// a load here is ignored until the first word has been taken
				if (word0_take) begin
					nxt_state = DSW_SECND;
				end
			end
			DSW_SECND: begin
				// The second word closes the burst
				if (word1_take) begin
					nxt_state = DSW_IDLE;
				end
				// A load on the positive edge before it starts the next one
				if (load_take) begin
					nxt_addr = link.addr;
					nxt_dir  = link.rw_dir;
					if (load_write) begin
						nxt_state = DSW_FIRST;
					end else begin
						nxt_state  = DSW_IDLE;
						nxt_rd_req = 1'b1;
					end
				end
			end
			default: nxt_state = DSW_IDLE;
		endcase
	end

	// Sequencer registers
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			state_ff  <= DSW_IDLE;
			addr_ff   <= '0;
			dir_ff    <= DIR_READ;
			rd_req_ff <= 1'b0;
		end else begin
			state_ff  <= nxt_state;
			addr_ff   <= nxt_addr;
			dir_ff    <= nxt_dir;
			rd_req_ff <= nxt_rd_req;
		end
	end

	// Word count of the running burst; every definition taken outside DSW_FIRST restarts it
	always_comb begin
		nxt_word_cnt = word_cnt_ff;
		if (load_take && state_ff != DSW_FIRST) begin
			nxt_word_cnt = '0;
		end else if (wr_en) begin
			nxt_word_cnt = word_cnt_ff + CNT_W'(1);
		end
	end

	// Word count register
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			word_cnt_ff <= '0;
		end else begin
			word_cnt_ff <= nxt_word_cnt;
		end
	end

	// Write word: selected nibbles from the link, the rest kept from the array
	always_comb begin
		wr_mask = '0;
		wr_mask[LO_NIB_LSB +: NIB_W] = {NIB_W{lo_sel}};
		wr_mask[HI_NIB_LSB +: NIB_W] = {NIB_W{hi_sel}};
		wr_en   = word0_take || word1_take;
		wr_idx  = {addr_ff, word_cnt_ff[0]};
		wr_word = (link.data_in & wr_mask) | (mem_ff[wr_idx] & ~wr_mask);
	end

	// Array: each entry loads only when its own index is written
	genvar e;
	generate
		for (e = 0; e < DEPTH; e++) begin : g_entry
			always_ff @(posedge clk_sys) begin
				if (wr_en && (wr_idx == WORD_IDX'(e))) begin
					mem_ff[e] <= wr_word;
				end
			end
		end
	endgenerate

	// Read-back: the addressed entry, registered once
	always_comb begin
		nxt_rd_data = mem_ff[rd_idx];
	end

	// Read-back register
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			rd_data_ff <= '0;
		end else begin
			rd_data_ff <= nxt_rd_data;
		end
	end

	// Read-back data and the read definition pulse
	assign rd_data = rd_data_ff;
	assign rd_req  = rd_req_ff;

	// Busy from a write definition until the second word of its burst
	assign wr_busy = (state_ff != DSW_IDLE);
endmodule

// ---- verilog/dsw_ctrl.sv ----
/*
 * Memory controller end: accepts a write request with two words and two
 * masks and drives one burst on the link, with the input clock phases
 * made by a divider from clk_sys.
 * Assumes the user holds its request until accepted.
 */
`timescale 1ns/1ps
module dsw_ctrl
	import dsw_pkg::*;
(
	// Clock and reset
	input  wire logic              clk_sys,
	input  wire logic              reset_n,
	// User request
	input  wire logic              req_valid,
	input  wire logic              req_read,
	input  wire logic [ADDR_W-1:0] req_addr,
	input  wire logic [DATA_W-1:0] req_word0,
	input  wire logic [DATA_W-1:0] req_word1,
	input  wire logic [1:0]        req_sel0_n,
	input  wire logic [1:0]        req_sel1_n,
	output logic                   req_ready,
	// Link
	dsw_link_if.ctrl               link
);
	logic      [1:0]        phase_ff, nxt_phase;
	dsw_state_t             state_ff, nxt_state;
	logic                   ld_ff, nxt_ld;
	logic                   dir_ff, nxt_dir;
	logic      [ADDR_W-1:0] addr_ff, nxt_addr;
	logic      [DATA_W-1:0] d_ff, nxt_d;
	logic      [1:0]        sel_ff, nxt_sel;
	logic      [DATA_W-1:0] w1_ff, nxt_w1;
	logic      [1:0]        s1_ff, nxt_s1;
	logic                   k_edge, kn_edge;

	// Phase divider: positive edge at phase 0, negative at phase 2
	assign k_edge  = (phase_ff == 2'b00);
	assign kn_edge = (phase_ff == 2'b10);
	assign req_ready = k_edge && (state_ff == DSW_IDLE);

	// Burst sequencing: drive data for the edge to come
	always_comb begin
		nxt_phase = phase_ff + 2'b01;
		nxt_state = state_ff;
		nxt_ld    = ld_ff;
		nxt_dir   = dir_ff;
		nxt_addr  = addr_ff;
		nxt_d     = d_ff;
		nxt_sel   = sel_ff;
		nxt_w1    = w1_ff;
		nxt_s1    = s1_ff;
		unique case (state_ff)
			DSW_IDLE: begin
				if (k_edge) begin
					nxt_ld = STROBE_IDLE;
				end
				if (req_ready && req_valid) begin
					nxt_ld   = STROBE_ACT;
					nxt_dir  = req_read ? DIR_READ : DIR_WRITE;
					nxt_addr = req_addr;
					nxt_d    = req_word0;
					nxt_sel  = req_sel0_n;
					nxt_w1   = req_word1;
					nxt_s1   = req_sel1_n;
					nxt_state = req_read ? DSW_IDLE : DSW_FIRST;
				end
			end
			DSW_FIRST: begin
				if (k_edge) begin
					nxt_ld    = STROBE_IDLE;
					nxt_state = DSW_SECND;
				end
			end
			DSW_SECND: begin
				// swap in second word after the positive edge
				if (k_edge) begin
					nxt_d     = w1_ff;
					nxt_sel   = s1_ff;
					nxt_state = DSW_IDLE;
				end
			end
			default: nxt_state = DSW_IDLE;
		endcase
	end

	// Registers
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			phase_ff <= 2'b00;
			state_ff <= DSW_IDLE;
			ld_ff    <= STROBE_IDLE;
			dir_ff   <= DIR_READ;
			addr_ff  <= '0;
			d_ff     <= '0;
			sel_ff   <= 2'b11;
			w1_ff    <= '0;
			s1_ff    <= 2'b11;
		end else begin
			phase_ff <= nxt_phase;
			state_ff <= nxt_state;
			ld_ff    <= nxt_ld;
			dir_ff   <= nxt_dir;
			addr_ff  <= nxt_addr;
			d_ff     <= nxt_d;
			sel_ff   <= nxt_sel;
			w1_ff    <= nxt_w1;
			s1_ff    <= nxt_s1;
		end
	end

	assign link.k_rise                  = k_edge && reset_n;
	assign link.kn_rise                 = kn_edge && reset_n;
	assign link.load_strobe_n           = ld_ff;
	assign link.rw_dir                  = dir_ff;
	assign link.addr                    = addr_ff;
	assign link.data_in                 = d_ff;
	assign link.low_nibble_write_sel_n  = sel_ff[0];
	assign link.high_nibble_write_sel_n = sel_ff[1];
endmodule

// ---- dv/dsw_link_assertions.sv ----
/*
 * Checker on the link between controller and SRAM write port.
 * Assumes one clk_sys domain and the phase enables k_rise and kn_rise.
 */
`timescale 1ns/1ps
module dsw_link_assertions
	import dsw_pkg::*;
(
	// Clock and reset
	input wire logic              clk_sys,
	input wire logic              reset_n,
	// Link signals
	input wire logic              k_rise,
	input wire logic              kn_rise,
	input wire logic              load_strobe_n,
	input wire logic              rw_dir,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] data_in,
	input wire logic              low_nibble_write_sel_n,
	input wire logic              high_nibble_write_sel_n
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	// Clock phases, load framing and held data
	a_k_period: assert property (k_rise |=> !k_rise [*3] ##1 k_rise)
		else $error("positive edge enable off its four cycle period");
	a_kn_phase: assert property (k_rise |-> ##2 kn_rise)
		else $error("negative edge enable not two cycles after positive");
	a_kn_alone: assert property (kn_rise |-> !k_rise)
		else $error("both edge enables in one cycle");
	a_load_stands: assert property ($fell(load_strobe_n) |-> !load_strobe_n [*4] ##1 load_strobe_n)
		else $error("load strobe not low for exactly four cycles");
	a_one_load: assert property (k_rise && !load_strobe_n |=> load_strobe_n)
		else $error("load strobe still low in the burst period");
	a_def_held: assert property (!load_strobe_n && !k_rise |=> $stable(addr) && $stable(rw_dir))
		else $error("address or direction moved while load pending");
	a_word0_held: assert property (k_rise && !load_strobe_n && rw_dir == DIR_WRITE
		|=> ($stable(data_in) && $stable(low_nibble_write_sel_n)) [*3]
		##1 ($stable(data_in) && k_rise))
		else $error("first word not held through its positive edge");
	a_kn_stable: assert property (kn_rise |-> $stable(data_in) && $stable(high_nibble_write_sel_n)
		&& $stable(low_nibble_write_sel_n))
		else $error("data or selects changed at a negative edge");
endmodule

// ---- dv/dsw_tb_top.sv ----
/*
 * Bench: controller and SRAM write port joined by the link.
 * Assumes clk_sys at 5 ns and read-back of the array through rd_idx.
 */
`timescale 1ns/1ps
module ddr_sram_write_port_nibble_mask_tb_top;
	import dsw_pkg::*;
	logic                clk_sys    = 1'b0;
	logic                reset_n    = 1'b0;
	logic                req_valid  = 1'b0;
	logic                req_read   = 1'b0;
	logic [ADDR_W-1:0]   req_addr   = '0;
	logic [DATA_W-1:0]   req_word0  = '0;
	logic [DATA_W-1:0]   req_word1  = '0;
	logic [1:0]          req_sel0_n = 2'h3;
	logic [1:0]          req_sel1_n = 2'h3;
	logic [WORD_IDX-1:0] rd_idx     = '0;
	logic                req_ready;
	logic [DATA_W-1:0]   rd_data;
	logic                wr_busy;
	logic                rd_req;
	int                  busy_seen  = 0;
	int                  rd_seen    = 0;
	// Write busy span: load edge to second word, a period and a half of the input clock, six clk_sys cycles
	localparam int       BUSY_CYC   = 6;
	logic [DATA_W-1:0]   mem_exp [DEPTH];
	int                  fail_count = 0;
	int                  checked    = 0;

	dsw_link_if link ();
	dsw_ctrl u_dsw_ctrl (.clk_sys(clk_sys), .reset_n(reset_n), .req_valid(req_valid),
		.req_read(req_read), .req_addr(req_addr), .req_word0(req_word0),
		.req_word1(req_word1), .req_sel0_n(req_sel0_n), .req_sel1_n(req_sel1_n),
		.req_ready(req_ready), .link(link));
	dsw_sram_port u_dsw_sram_port (.clk_sys(clk_sys), .reset_n(reset_n), .link(link),
		.rd_idx(rd_idx), .rd_data(rd_data), .wr_busy(wr_busy), .rd_req(rd_req));
	dsw_link_assertions u_dsw_link_assertions (.clk_sys(clk_sys), .reset_n(reset_n),
		.k_rise(link.k_rise), .kn_rise(link.kn_rise), .load_strobe_n(link.load_strobe_n),
		.rw_dir(link.rw_dir), .addr(link.addr), .data_in(link.data_in),
		.low_nibble_write_sel_n(link.low_nibble_write_sel_n),
		.high_nibble_write_sel_n(link.high_nibble_write_sel_n));

	// Clock
	always #2.5 clk_sys = ~clk_sys;

	// Status cycles seen during each transfer
	always @(posedge clk_sys) begin
		if (wr_busy === 1'b1) busy_seen++;
		if (rd_req === 1'b1) rd_seen++;
	end

	// Expected word after a masked write
	function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old, nw,
		input logic [1:0] s);
		merge = old;
		if (s[0] === STROBE_ACT) merge[LO_NIB_LSB +: NIB_W] = nw[LO_NIB_LSB +: NIB_W];
		if (s[1] === STROBE_ACT) merge[HI_NIB_LSB +: NIB_W] = nw[HI_NIB_LSB +: NIB_W];
	endfunction

	// One request, held until accepted, then wait out the burst
	task automatic xfer(input logic rd, input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] w0, w1, input logic [1:0] s0, s1);
		int n;
		req_valid  <= 1'b1;
		req_read   <= rd;
		req_addr   <= a;
		req_word0  <= w0;
		req_word1  <= w1;
		req_sel0_n <= s0;
		req_sel1_n <= s1;
		n = 0;
		busy_seen = 0;
		rd_seen = 0;
		do begin
			@(negedge clk_sys);
			n++;
		end while (req_ready !== 1'b1 && n < 20);
		@(posedge clk_sys);
		req_valid <= 1'b0;
		if (n >= 20) begin
			fail_count++;
			$display("mismatch req_ready expected 1 seen 0");
		end
		if (rd == DIR_WRITE) begin
			mem_exp[{a, 1'b0}] = merge(mem_exp[{a, 1'b0}], w0, s0);
			mem_exp[{a, 1'b1}] = merge(mem_exp[{a, 1'b1}], w1, s1);
		end
		repeat (12) @(posedge clk_sys);
		checked += 2;
		if (rd_seen != ((rd == DIR_READ) ? 1 : 0)) begin
			fail_count++;
			$display("mismatch rd_req expected %0d seen %0d", (rd == DIR_READ) ? 1 : 0, rd_seen);
		end
		if (busy_seen != ((rd == DIR_WRITE) ? BUSY_CYC : 0)) begin
			fail_count++;
			$display("mismatch wr_busy expected %0d seen %0d",
				(rd == DIR_WRITE) ? BUSY_CYC : 0, busy_seen);
		end
	endtask

	// Read one array word back and compare
	task automatic chk(input logic [WORD_IDX-1:0] i);
		rd_idx <= i;
		@(posedge clk_sys);
		@(negedge clk_sys);
		checked++;
		if (rd_data !== mem_exp[i]) begin
			fail_count++;
			$display("mismatch rd_data[%0d] expected %h seen %h", i, mem_exp[i], rd_data);
		end
		@(posedge clk_sys);
	endtask

	// Verdict and end of run
	task automatic test_done;
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// Watchdog against a hung handshake
	initial begin
		repeat (3000) @(posedge clk_sys);
		fail_count++;
		$display("mismatch watchdog expected done seen running");
		test_done();
	end

	// Tests
	initial begin
		repeat (4) @(posedge clk_sys);
		reset_n <= 1'b1;
		xfer(1'b0, 6'h05, 8'hA5, 8'h3C, 2'h0, 2'h0);
		xfer(1'b0, 6'h3F, 8'h0F, 8'hF0, 2'h0, 2'h0);
		chk(7'h0A);
		chk(7'h0B);
		chk(7'h7E);
		chk(7'h7F);
		$display("test full bursts done");
		for (int m = 0; m < 4; m++) begin
			xfer(1'b0, 6'h09, 8'h5A, 8'hC3, 2'h0, 2'h0);
			xfer(1'b0, 6'h09, 8'h96, 8'h69, 2'(m), ~2'(m));
			chk(7'h12);
			chk(7'h13);
		end
		$display("test nibble masks done");
		xfer(1'b1, 6'h05, 8'hFF, 8'hFF, 2'h0, 2'h0);
		chk(7'h0A);
		chk(7'h0B);
		$display("test read direction done");
		test_done();
	end
endmodule
